// ### rtl/crsc_top.v
// Clock recovery status and error counter bank with APB slave
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "crsc_consts.vh"
module crsc_top #(
   parameter NP = 8,
   parameter AW = 12,
   parameter [2:0] VERSION_NUM = 3'h1, // Arbitrary value
   parameter [2:0] RELEASE_NUM = 3'h0 // Arbitrary value
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Event pulses from the recovery logic
   input wire tx_fifo_overflow,
   input wire [NP-1:0] rx_fifo_underflow,
   input wire [NP-1:0] rx_fifo_overflow,
   input wire [NP-1:0] generator_reset,
   input wire [NP-1:0] invalid_stamp,
   input wire [NP-1:0] adaptive_late,
   // Lock losses and window ticks
   input wire [NP-1:0] filter_lock_loss,
   input wire [NP-1:0] stamp_lock_loss,
   input wire [NP-1:0] adaptive_lock_loss,
   input wire [NP-1:0] stamp_period_tick,
   input wire [NP-1:0] cell_tick,
   // Live loop states
   input wire [NP-1:0] adaptive_clipped,
   input wire [NP-1:0] stamp_holdover,
   input wire [NP-1:0] free_run,
   // Receive FIFO test readout
   input wire [4*NP-1:0] rx_fifo_head,
   input wire [NP-1:0] rx_fifo_nonempty,
   output reg [NP-1:0] rx_fifo_pop,
   // Test injection toward the transmit FIFO
   output reg [NP-1:0] stamp_inject_enable,
   output reg [4*NP-1:0] stamp_inject_value,
   output reg [NP-1:0] stamp_inject_strobe,
   // Per-port interrupt summary
   output reg [7*NP-1:0] port_interrupt_summary
);

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------

   // Saturating increment of a five-bit lock loss tally
   function [4:0] inc_sat5;
      input [4:0] cnt;
      input evt;
      begin
         if (evt && (cnt != 5'h1F)) begin
            inc_sat5 = cnt + 5'h01;
         end else begin
            inc_sat5 = cnt;
         end
      end
   endfunction

   // True for a per-port register index with port bits stripped
   function is_port_idx;
      input [9:0] li;
      begin
         is_port_idx = (li == `CRSC_IDX_RX_UNF) ||
            (li == `CRSC_IDX_RX_OVF) || (li == `CRSC_IDX_GEN_RST) ||
            (li == `CRSC_IDX_INVALID) || (li == `CRSC_IDX_LATE) ||
            (li == `CRSC_IDX_OOL) || (li == `CRSC_IDX_STAT) ||
            (li == `CRSC_IDX_TEST_OUT) || (li == `CRSC_IDX_SUMMARY) ||
            (li == `CRSC_IDX_TEST_IN) || (li == `CRSC_IDX_THRESH);
      end
   endfunction

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------

   localparam [3:0] NP_W = NP[3:0];

   // Setup phase not in access; first access cycle captures, second completes
   wire access = psel & penable;
   wire rd_capture = access & ~pready & ~pwrite;
   wire wr_commit = access & pready & pwrite;
   wire [9:0] idx = paddr[11:2];
   wire [2:0] aport = idx[7:5];
   wire [9:0] lidx = idx & `CRSC_PORT_MASK;
   wire glob_tx = (idx == `CRSC_IDX_TX_OVF);
   wire glob_ver = (idx == `CRSC_IDX_VERSION);
   wire port_ok = is_port_idx(lidx) && ({1'b0, aport} < NP_W);
   wire mapped = glob_tx | glob_ver | port_ok;

   // -------------------------------------------------------------------
   // Shared transmit FIFO overflow counter
   // -------------------------------------------------------------------

   wire [7:0] cnt_tx;

   // Cleared when software reads it
   crsc_sat_counter #(
      .W(8)
   ) u_tx_ovf (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(tx_fifo_overflow),
      .clear(rd_capture & glob_tx),
      .count(cnt_tx)
   );

   // -------------------------------------------------------------------
   // Per-port logic
   // -------------------------------------------------------------------

   wire [8*NP-1:0] cnt_unf;
   wire [8*NP-1:0] cnt_ovf;
   wire [8*NP-1:0] cnt_gen;
   wire [8*NP-1:0] cnt_inv;
   wire [8*NP-1:0] cnt_late;
   wire [16*NP-1:0] port_words;

   genvar p;
   generate
      for (p = 0; p < NP; p = p + 1) begin : g_port
         localparam integer PID = p;
         reg [3:0] win_stamp;
         reg [3:0] win_cell;
         reg [4:0] loss_filt;
         reg [4:0] loss_stamp;
         reg [4:0] loss_adapt;
         reg [2:0] ool;
         reg [2:0] stat;
         reg [11:0] thresh;
         wire hit = ({29'h0, aport} == PID);
         wire rd = rd_capture & hit;
         wire wr = wr_commit & hit;
         wire stamp_end;
         wire cell_end;
         wire [3:0] thr_filt;
         wire [3:0] thr_stamp;
         wire [3:0] thr_adapt;
         wire [2:0] ool_set;
         wire [2:0] live;
         wire [3:0] test_val;
         wire [6:0] summary;

         // Saturating event counters, each cleared by its own read
         crsc_sat_counter #(
            .W(8)
         ) u_unf (
            .pclk(pclk),
            .presetn(presetn),
            .event_in(rx_fifo_underflow[p]),
            .clear(rd & (lidx == `CRSC_IDX_RX_UNF)),
            .count(cnt_unf[8*p +: 8])
         );
         crsc_sat_counter #(
            .W(8)
         ) u_ovf (
            .pclk(pclk),
            .presetn(presetn),
            .event_in(rx_fifo_overflow[p]),
            .clear(rd & (lidx == `CRSC_IDX_RX_OVF)),
            .count(cnt_ovf[8*p +: 8])
         );
         crsc_sat_counter #(
            .W(8)
         ) u_gen (
            .pclk(pclk),
            .presetn(presetn),
            .event_in(generator_reset[p]),
            .clear(rd & (lidx == `CRSC_IDX_GEN_RST)),
            .count(cnt_gen[8*p +: 8])
         );
         crsc_sat_counter #(
            .W(8)
         ) u_inv (
            .pclk(pclk),
            .presetn(presetn),
            .event_in(invalid_stamp[p]),
            .clear(rd & (lidx == `CRSC_IDX_INVALID)),
            .count(cnt_inv[8*p +: 8])
         );
         crsc_sat_counter #(
            .W(8)
         ) u_late (
            .pclk(pclk),
            .presetn(presetn),
            .event_in(adaptive_late[p]),
            .clear(rd & (lidx == `CRSC_IDX_LATE)),
            .count(cnt_late[8*p +: 8])
         );

         // Window ends after sixteen stamp periods or sixteen cells
         assign stamp_end = stamp_period_tick[p] &
            (win_stamp == `CRSC_STAMP_WINDOW);
         assign cell_end = cell_tick[p] &
            (win_cell == `CRSC_CELL_WINDOW);
         assign thr_filt = thresh[`CRSC_THR_FILT_LSB +: 4];
         assign thr_stamp = thresh[`CRSC_THR_STAMP_LSB +: 4];
         assign thr_adapt = thresh[`CRSC_THR_ADAPT_LSB +: 4];
         assign ool_set[`CRSC_OOL_FILT] =
            (loss_filt > {1'b0, thr_filt});
         assign ool_set[`CRSC_OOL_STAMP] =
            (loss_stamp > {1'b0, thr_stamp});
         assign ool_set[`CRSC_OOL_ADAPT] =
            (loss_adapt > {1'b0, thr_adapt});
         assign live[`CRSC_STAT_MAX] = adaptive_clipped[p];
         assign live[`CRSC_STAT_HOV] = stamp_holdover[p];
         assign live[`CRSC_STAT_FRR] = free_run[p];

         // Window position and lock losses; a loss on the last tick
         // opens the next window
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               win_stamp <= 4'h0;
               win_cell <= 4'h0;
               loss_filt <= 5'h00;
               loss_stamp <= 5'h00;
               loss_adapt <= 5'h00;
            end else begin
               if (stamp_period_tick[p]) begin
                  win_stamp <= win_stamp + 4'h1;
               end
               if (cell_tick[p]) begin
                  win_cell <= win_cell + 4'h1;
               end
               if (stamp_end) begin
                  loss_filt <= {4'h0, filter_lock_loss[p]};
                  loss_stamp <= {4'h0, stamp_lock_loss[p]};
               end else begin
                  loss_filt <= inc_sat5(loss_filt, filter_lock_loss[p]);
                  loss_stamp <= inc_sat5(loss_stamp, stamp_lock_loss[p]);
               end
               if (cell_end) begin
                  loss_adapt <= {4'h0, adaptive_lock_loss[p]};
               end else begin
                  loss_adapt <= inc_sat5(loss_adapt, adaptive_lock_loss[p]);
               end
            end
         end

         // Sticky flags and status; a set in the read cycle wins
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ool <= `CRSC_RST_OOL;
               stat <= `CRSC_RST_STAT;
            end else begin
               if (rd && (lidx == `CRSC_IDX_OOL)) begin
                  ool <= ool_set;
               end else begin
                  ool <= ool | ool_set;
               end
               if (rd && (lidx == `CRSC_IDX_STAT)) begin
                  stat <= live;
               end else begin
                  stat <= stat | live;
               end
            end
         end

         // Threshold and test injection written by software
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               thresh <= `CRSC_RST_THRESH;
               stamp_inject_enable[p] <= 1'b0;
               stamp_inject_value[4*p +: 4] <= 4'h0;
               stamp_inject_strobe[p] <= 1'b0;
            end else begin
               stamp_inject_strobe[p] <= 1'b0;
               if (wr && (lidx == `CRSC_IDX_THRESH)) begin
                  thresh <= pwdata[11:0];
               end
               if (wr && (lidx == `CRSC_IDX_TEST_IN)) begin
                  stamp_inject_enable[p] <= pwdata[`CRSC_TIN_ENA];
                  stamp_inject_value[4*p +: 4] <=
                     pwdata[`CRSC_TIN_VAL_LSB +: 4];
                  stamp_inject_strobe[p] <= pwdata[`CRSC_TIN_ENA];
               end
            end
         end

         // One pop per test output read while data is available
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rx_fifo_pop[p] <= 1'b0;
            end else begin
               rx_fifo_pop[p] <= rd & (lidx == `CRSC_IDX_TEST_OUT) &
                  rx_fifo_nonempty[p];
            end
         end

         // Head value shows only while test input is enabled
         assign test_val = stamp_inject_enable[p] ?
            rx_fifo_head[4*p +: 4] : 4'h0;

         // Summary bits follow nonzero sources
         assign summary[`CRSC_SUM_OOL] = |ool;
         assign summary[`CRSC_SUM_LATE] = |cnt_late[8*p +: 8];
         assign summary[`CRSC_SUM_INVALID] = |cnt_inv[8*p +: 8];
         assign summary[`CRSC_SUM_RX_OVF] = |cnt_ovf[8*p +: 8];
         assign summary[`CRSC_SUM_RX_UNF] = |cnt_unf[8*p +: 8];
         assign summary[`CRSC_SUM_TEST_OUT] = rx_fifo_nonempty[p];
         assign summary[`CRSC_SUM_GEN_RST] = |cnt_gen[8*p +: 8];

         // Registered summary output
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               port_interrupt_summary[7*p +: 7] <= 7'h00;
            end else begin
               port_interrupt_summary[7*p +: 7] <= summary;
            end
         end

         // Read word of this port
         assign port_words[16*p +: 16] =
            (lidx == `CRSC_IDX_RX_UNF) ? {8'h00, cnt_unf[8*p +: 8]} :
            (lidx == `CRSC_IDX_RX_OVF) ? {8'h00, cnt_ovf[8*p +: 8]} :
            (lidx == `CRSC_IDX_GEN_RST) ? {8'h00, cnt_gen[8*p +: 8]} :
            (lidx == `CRSC_IDX_INVALID) ? {8'h00, cnt_inv[8*p +: 8]} :
            (lidx == `CRSC_IDX_LATE) ? {8'h00, cnt_late[8*p +: 8]} :
            (lidx == `CRSC_IDX_OOL) ? {13'h0000, ool} :
            (lidx == `CRSC_IDX_STAT) ? {13'h0000, stat} :
            (lidx == `CRSC_IDX_TEST_OUT) ?
               {11'h000, test_val, rx_fifo_nonempty[p]} :
            (lidx == `CRSC_IDX_SUMMARY) ? {9'h000, summary} :
            (lidx == `CRSC_IDX_TEST_IN) ?
               {11'h000, stamp_inject_value[4*p +: 4],
                stamp_inject_enable[p]} :
            (lidx == `CRSC_IDX_THRESH) ? {4'h0, thresh} :
            16'h0000;
      end
   endgenerate

   // -------------------------------------------------------------------
   // Read data and APB answer
   // -------------------------------------------------------------------

   reg [15:0] rd_word;

   // Select the addressed word; version register has no write path
   always @* begin
      rd_word = 16'h0000;
      if (glob_tx) begin
         rd_word = {8'h00, cnt_tx};
      end else if (glob_ver) begin
         rd_word = {10'h000, VERSION_NUM, RELEASE_NUM};
      end else if (port_ok) begin
         rd_word = port_words[{aport, 4'h0} +: 16];
      end
   end

   // One wait state: capture on first access edge, ready on the next
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
         pslverr <= ~mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

// ### pkg/crsc_consts.vh
// Register indices, field positions, reset values and windows of the bank
`ifndef CRSC_CONSTS_VH
`define CRSC_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CRSC_IDX_TX_OVF 10'h112
`define CRSC_IDX_VERSION 10'h113
`define CRSC_IDX_RX_UNF 10'h114
`define CRSC_IDX_RX_OVF 10'h115
`define CRSC_IDX_GEN_RST 10'h116
`define CRSC_IDX_INVALID 10'h117
`define CRSC_IDX_LATE 10'h118
`define CRSC_IDX_OOL 10'h119
`define CRSC_IDX_STAT 10'h11A
`define CRSC_IDX_TEST_OUT 10'h11B
`define CRSC_IDX_SUMMARY 10'h105
`define CRSC_IDX_TEST_IN 10'h107
`define CRSC_IDX_THRESH 10'h10F
// Port number sits in index bits 7:5 (stride of 32 indices)
`define CRSC_PORT_MASK 10'h31F
`define CRSC_PORT_LSB 5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CRSC_OOL_ADAPT 0
`define CRSC_OOL_STAMP 1
`define CRSC_OOL_FILT 2
`define CRSC_STAT_FRR 0
`define CRSC_STAT_HOV 1
`define CRSC_STAT_MAX 2
`define CRSC_TOUT_DAV 0
`define CRSC_TOUT_VAL_LSB 1
`define CRSC_TIN_ENA 0
`define CRSC_TIN_VAL_LSB 1
`define CRSC_THR_ADAPT_LSB 0
`define CRSC_THR_STAMP_LSB 4
`define CRSC_THR_FILT_LSB 8
`define CRSC_VER_REL_LSB 0
`define CRSC_VER_VER_LSB 3
`define CRSC_SUM_OOL 0
`define CRSC_SUM_LATE 1
`define CRSC_SUM_INVALID 2
`define CRSC_SUM_RX_OVF 3
`define CRSC_SUM_RX_UNF 4
`define CRSC_SUM_TEST_OUT 5
`define CRSC_SUM_GEN_RST 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRSC_RST_COUNT 8'h00
`define CRSC_RST_OOL 3'h0
`define CRSC_RST_STAT 3'h1
`define CRSC_RST_THRESH 12'h111
`define CRSC_RST_TEST_IN 5'h00

// ----------------------------------------------------------------------
// Lock-loss evaluation windows
// ----------------------------------------------------------------------
`define CRSC_STAMP_WINDOW 4'hF
`define CRSC_CELL_WINDOW 4'hF

`endif

// ### rtl/crsc_sat_counter.v
// Saturating event counter cleared by a register read
`timescale 1ns/1ns
module crsc_sat_counter #(
   parameter W = 8
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Event and clear
   input wire event_in,
   input wire clear,
   // Count value
   output reg [W-1:0] count
);

   // Event in the clearing cycle leaves the counter at one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {W{1'b0}};
      end else if (clear) begin
         count <= {{(W-1){1'b0}}, event_in};
      end else if (event_in && (count != {W{1'b1}})) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ### testbench/crsc_top_asserts.sv
// Port assertions for the status counter bank
`timescale 1ns/1ns
module crsc_top_asserts #(
   parameter NP = 8,
   parameter AW = 12
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Test readout and injection
   input wire [NP-1:0] rx_fifo_nonempty,
   input wire [NP-1:0] rx_fifo_pop,
   input wire [NP-1:0] stamp_inject_enable,
   input wire [4*NP-1:0] stamp_inject_value,
   input wire [NP-1:0] stamp_inject_strobe
);
   // ------------------------------------------------------------
   // Decode of the transfer in flight
   // ------------------------------------------------------------
   wire [9:0] idx = paddr[11:2];
   wire [2:0] prt = idx[7:5];
   wire first = psel && penable && !pready;
   wire done = psel && penable && pready;
   wire test_out = idx[4:0] == 5'h1B && idx[9:8] == 2'h1;
   wire test_in = idx[4:0] == 5'h07 && idx[9:8] == 2'h1;
   wire out_read = first && !pwrite && test_out;
   wire in_write = done && pwrite && test_in;

   // One clock domain, reset disables all checks
   default clocking dflt @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_ready_one_wait: assert property (first |=> pready)
      else $error("pready missing after first access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held for more than one cycle");
   a_error_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without pready or with data");
   a_write_no_data: assert property (first && pwrite |=> prdata == 32'h0)
      else $error("write returned nonzero read data");
   a_pop_on_read: assert property (
      out_read && rx_fifo_nonempty[prt] |=>
      rx_fifo_pop[$past(prt)] && $onehot(rx_fifo_pop))
      else $error("test output read did not pop its port");
   a_pop_cause: assert property (rx_fifo_pop != 0 |-> $past(out_read))
      else $error("pop without a test output read");
   a_pop_single: assert property (rx_fifo_pop != 0 |=> rx_fifo_pop == 0)
      else $error("pop longer than one cycle");
   a_strobe_on_write: assert property (
      in_write && pwdata[0] |-> ##[1:2] $onehot(stamp_inject_strobe))
      else $error("inject write gave no strobe");
   a_strobe_enabled: assert property (
      stamp_inject_strobe != 0 |->
      (stamp_inject_strobe & ~stamp_inject_enable) == 0)
      else $error("strobe on a port with inject disabled");
   a_inject_held: assert property (
      !$stable(stamp_inject_enable) || !$stable(stamp_inject_value) |->
      $past(in_write) || $past(in_write, 2))
      else $error("inject outputs changed without a write");
endmodule

bind crsc_top crsc_top_asserts #(.NP(NP), .AW(AW)) i_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_fifo_nonempty(rx_fifo_nonempty),
   .rx_fifo_pop(rx_fifo_pop), .stamp_inject_enable(stamp_inject_enable),
   .stamp_inject_value(stamp_inject_value),
   .stamp_inject_strobe(stamp_inject_strobe));

// ### testbench/crsc_top_test.sv
// Self-checking testbench for the status counter bank
`timescale 1ns/1ns
module crsc_top_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   // APB side
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   // Events, losses, ticks and live levels
   logic tx_fifo_overflow = 1'b0;
   logic [7:0] rx_fifo_underflow = 8'h00, rx_fifo_overflow = 8'h00;
   logic [7:0] generator_reset = 8'h00, invalid_stamp = 8'h00;
   logic [7:0] adaptive_late = 8'h00, filter_lock_loss = 8'h00;
   logic [7:0] stamp_lock_loss = 8'h00, adaptive_lock_loss = 8'h00;
   logic [7:0] stamp_period_tick = 8'h00, cell_tick = 8'h00;
   logic [7:0] adaptive_clipped = 8'h00, stamp_holdover = 8'h00;
   logic [7:0] free_run = 8'h00, rx_fifo_nonempty = 8'h00;
   logic [31:0] rx_fifo_head = 32'h0, stamp_inject_value;
   logic [7:0] rx_fifo_pop, stamp_inject_enable, stamp_inject_strobe;
   logic [55:0] port_interrupt_summary;
   // Bench state
   logic [31:0] seed = 32'hCBB6829E, rdv;
   logic erv;
   logic [3:0] v;
   logic [3:0] q[$];
   int fails = 0, comparisons = 0, cycles = 0, k, p, n;

   crsc_top #(.VERSION_NUM(3'h5), .RELEASE_NUM(3'h2)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .tx_fifo_overflow(tx_fifo_overflow),
      .rx_fifo_underflow(rx_fifo_underflow),
      .rx_fifo_overflow(rx_fifo_overflow),
      .generator_reset(generator_reset), .invalid_stamp(invalid_stamp),
      .adaptive_late(adaptive_late), .filter_lock_loss(filter_lock_loss),
      .stamp_lock_loss(stamp_lock_loss),
      .adaptive_lock_loss(adaptive_lock_loss),
      .stamp_period_tick(stamp_period_tick), .cell_tick(cell_tick),
      .adaptive_clipped(adaptive_clipped), .stamp_holdover(stamp_holdover),
      .free_run(free_run), .rx_fifo_head(rx_fifo_head),
      .rx_fifo_nonempty(rx_fifo_nonempty), .rx_fifo_pop(rx_fifo_pop),
      .stamp_inject_enable(stamp_inject_enable),
      .stamp_inject_value(stamp_inject_value),
      .stamp_inject_strobe(stamp_inject_strobe),
      .port_interrupt_summary(port_interrupt_summary));

   // Clock of 10 ns period
   always #5 pclk = ~pclk;

   // Hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails = fails + 1;
         wrap_up();
      end
   end

   // Receive FIFO behind every port, popped by any pop pulse
   always @(posedge pclk) begin
      if (|rx_fifo_pop && q.size() > 0) void'(q.pop_front());
      rx_fifo_nonempty <= {8{q.size() > 0}};
      rx_fifo_head <= {8{(q.size() > 0) ? q[0] : 4'h0}};
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Counter index of event kind e on port pt
   function logic [9:0] ridx(input int e, input int pt);
      return (e == 0) ? 10'h112 : 10'(10'h113 + e + 32 * pt);
   endfunction

   // Summary bit position of event kind e
   function int sbit(input int e);
      return (e == 1) ? 4 : (e == 2) ? 3 : (e == 3) ? 6 : (e == 4) ? 2 : 1;
   endfunction

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [9:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 32'h0);
      chk("prdata", {16'h0, exp}, rdv);
      chk_bit("pslverr", 1'b0, erv);
   endtask

   task set_ev(input int e, input int pt, input logic x);
      case (e)
         0: tx_fifo_overflow <= x;
         1: rx_fifo_underflow[pt] <= x;
         2: rx_fifo_overflow[pt] <= x;
         3: generator_reset[pt] <= x;
         4: invalid_stamp[pt] <= x;
         5: adaptive_late[pt] <= x;
         6: adaptive_lock_loss[pt] <= x;
         7: stamp_lock_loss[pt] <= x;
         8: filter_lock_loss[pt] <= x;
         9: cell_tick[pt] <= x;
         default: stamp_period_tick[pt] <= x;
      endcase
   endtask

   task pulse(input int e, input int pt, input int cnt);
      repeat (cnt) begin
         @(posedge pclk);
         set_ev(e, pt, 1'b1);
      end
      @(posedge pclk);
      set_ev(e, pt, 1'b0);
   endtask

   task lvl(input logic [2:0] x);
      adaptive_clipped[1] <= x[2];
      stamp_holdover[1] <= x[1];
      free_run[1] <= x[0];
   endtask

   task wrap_up();
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, read-only version, ignored writes, unmapped places
      apb(1'b1, 10'h113, 32'hFFFF);
      apb(1'b1, 10'h114, 32'h00FF);
      rd(10'h113, 16'h002A);
      rd(10'h113, 16'h002A);
      rd(10'h112, 16'h0000);
      rd(10'h10F, 16'h0111);
      for (k = 4; k < 12; k++) rd(10'(10'h110 + k), 16'(k == 10));
      rd(10'h11A, 16'h0000);
      apb(1'b0, 10'h000, 32'h0);
      chk_bit("pslverr", 1'b1, erv);
      chk("prdata", 32'h0, rdv);
      apb(1'b1, 10'h3FF, 32'h1234);
      chk_bit("pslverr", 1'b1, erv);
      // Random counts with summary bits
      for (int i = 0; i < 12; i++) begin
         k = i % 6;
         p = rnd() % 8;
         n = 1 + rnd() % 20;
         pulse(k, p, n);
         if (k > 0) rd(10'(10'h105 + 32 * p), 16'(1 << sbit(k)));
         if (k > 0) chk_bit("summary", 1'b1, port_interrupt_summary[7 * p + sbit(k)]);
         rd(ridx(k, p), 16'(n));
         rd(ridx(k, p), 16'h0000);
         if (k > 0) chk_bit("summary", 1'b0, port_interrupt_summary[7 * p + sbit(k)]);
      end
      // Saturation, then an event on the clearing edge
      for (k = 0; k < 6; k++) begin
         pulse(k, 2, 260);
         rd(ridx(k, 2), 16'h00FF);
         pulse(k, 6, 3);
         fork
            rd(ridx(k, 6), 16'h0003);
            begin
               repeat (2) @(posedge pclk);
               set_ev(k, 6, 1'b1);
               @(posedge pclk);
               set_ev(k, 6, 1'b0);
            end
         join
         rd(ridx(k, 6), 16'h0001);
      end
      // Lock-loss flags against thresholds over 16-tick windows
      apb(1'b1, 10'h18F, 32'h0132);
      rd(10'h18F, 16'h0132);
      for (k = 0; k < 3; k++) begin
         n = (k == 0) ? 2 : (k == 1) ? 3 : 1;
         pulse(6 + k, 4, n);
         pulse((k == 0) ? 9 : 10, 4, 16);
         pulse(6 + k, 4, n);
         rd(10'h199, 16'h0000);
         pulse(6 + k, 4, 1);
         rd(10'h199, 16'(1 << k));
         pulse((k == 0) ? 9 : 10, 4, 16);
         rd(10'h199, 16'(1 << k));
         rd(10'h199, 16'h0000);
      end
      // Status bits, sticky then live
      rd(10'h13A, 16'h0001);
      v = 4'(rnd() % 7 + 1);
      lvl(v[2:0]);
      repeat (2) @(posedge pclk);
      lvl(3'b000);
      rd(10'h13A, {13'h0, v[2:0]});
      rd(10'h13A, 16'h0000);
      lvl(3'b111);
      rd(10'h13A, 16'h0007);
      rd(10'h13A, 16'h0007);
      lvl(3'b000);
      // Injection and receive FIFO readout on port 3
      v = 4'(rnd());
      apb(1'b1, 10'h167, {27'h0, v, 1'b1});
      rd(10'h167, {11'h0, v, 1'b1});
      chk_bit("inject_enable", 1'b1, stamp_inject_enable[3]);
      chk("inject_value", {28'h0, v}, {28'h0, stamp_inject_value[15:12]});
      repeat (3) q.push_back(4'(rnd()));
      repeat (2) @(posedge pclk);
      repeat (3) begin
         rd(10'h17B, {11'h0, q[0], 1'b1});
         @(posedge pclk);
      end
      rd(10'h17B, 16'h0000);
      apb(1'b1, 10'h167, 32'h0);
      q.push_back(4'hF);
      repeat (2) @(posedge pclk);
      rd(10'h17B, 16'h0001);
      rd(10'h17B, 16'h0000);
      wrap_up();
   end
endmodule
